// [src/arb_result_bank.v]
// Read-only bank of converter results: battery low byte, top-cell high and
// low bytes, thermistor ratio high byte. Assumes the converter hands in a
// 16-bit two's-complement word with a one-cycle update strobe per channel,
// and that the serial register front end issues one-cycle read strobes.
//
// Notes on behaviour
// - Offset 0x1E returns the low byte of the battery result, bit 0 worth 1 mV up to 128 mV at bit 7.
// - Offset 0x1F returns the top-cell high byte, bits 14 to 8 worth 16384 mV down to 256 mV.
// - Bit 15 of every result is the sign and the whole word is two's complement.
// - Offset 0x20 returns the top-cell low byte, bit 0 worth 1 mV up to 128 mV at bit 7.
// - Cell balancing uses its own comparator, so the top-cell value here is reporting only.
// - Offset 0x21 returns the thermistor ratio high byte, bit 9 worth 50 % and bit 8 worth 25 %.
// - All fields are read-only, reset to 00h, cleared by register-defaults but not by watchdog expiry.
// - A register-defaults request restores defaults, restarts the safety timer and then self-clears.
`timescale 1ns/1ps
`default_nettype none
`include "arb_consts.vh"

module arb_result_bank (
  // Clock and reset
  input wire mclk_in,
  input wire rstn_in,
  // Converter results
  input wire bat_result_valid_in,
  input wire [`ARB_RES_W-1:0] bat_result_in,
  input wire top_result_valid_in,
  input wire [`ARB_RES_W-1:0] top_result_in,
  input wire therm_result_valid_in,
  input wire [`ARB_RES_W-1:0] therm_result_in,
  // Register access
  input wire rd_strobe_in,
  input wire wr_strobe_in,
  input wire [`ARB_ADDR_W-1:0] addr_in,
  input wire [`ARB_DATA_W-1:0] wdata_in,
  output reg [`ARB_DATA_W-1:0] rdata_out,
  output reg rdata_valid_out,
  // Register defaults and watchdog
  input wire reg_defaults_req_in,
  input wire watchdog_expired_in,
  output reg safety_timer_reset_out,
  output reg reg_defaults_busy_out
);

  // Defaults handshake: one pulse cycle, then back to idle
  localparam DFLT_IDLE = 1'h0;
  localparam DFLT_PULSE = 1'h1;

  // Channel order in the packed buses: battery, top cell, thermistor
  wire [`ARB_N_CHAN-1:0] chan_valid;
  wire [`ARB_N_CHAN*`ARB_RES_W-1:0] chan_word;
  wire [`ARB_N_CHAN*`ARB_RES_W-1:0] chan_keep;
  wire [`ARB_N_CHAN*`ARB_RES_W-1:0] chan_result;
  wire [`ARB_RES_W-1:0] bat_word;
  wire [`ARB_RES_W-1:0] top_word;
  wire [`ARB_RES_W-1:0] therm_word;
  wire clear_results;

  reg dflt_state_reg;
  reg dflt_state_next;
  reg safety_timer_reset_next;
  reg reg_defaults_busy_next;
  reg [`ARB_DATA_W-1:0] rdata_next;
  reg rdata_valid_next;

  // Upper byte of a result word, sign bit on top
  function [`ARB_DATA_W-1:0] high_byte;
    input [`ARB_RES_W-1:0] w;
    begin
      high_byte = w[`ARB_SIGN_BIT:`ARB_HIGH_LO];
    end
  endfunction

  // Lower byte of a result word
  function [`ARB_DATA_W-1:0] low_byte;
    input [`ARB_RES_W-1:0] w;
    begin
      low_byte = w[`ARB_LOW_HI:`ARB_LOW_LO];
    end
  endfunction

  // Unweighted thermistor bits clear only on non-negative words;
  // a negative word keeps its two's-complement form intact
  function [`ARB_RES_W-1:0] therm_keep;
    input [`ARB_RES_W-1:0] w;
    begin
      if (w[`ARB_SIGN_BIT])
        therm_keep = `ARB_KEEP_ALL;
      else
        therm_keep = `ARB_THERM_ZERO_MASK;
    end
  endfunction

  assign chan_valid = {therm_result_valid_in, top_result_valid_in, bat_result_valid_in};
  assign chan_word = {therm_result_in, top_result_in, bat_result_in};
  // Top-cell word is reporting only; balancing never looks at it
  assign chan_keep = {therm_keep(therm_result_in), `ARB_KEEP_ALL, `ARB_KEEP_ALL};

  // Results clear in the cycle after the pulse is raised
  assign clear_results = (dflt_state_reg == DFLT_PULSE);

  // One capture register per channel
  genvar ch;
  generate
    for (ch = 0; ch < `ARB_N_CHAN; ch = ch + 1) begin : g_chan
      reg [`ARB_RES_W-1:0] result_reg;
      reg [`ARB_RES_W-1:0] result_next;

      // Clear wins over a coincident capture; watchdog has no path in
      always @* begin
        result_next = result_reg;
        if (clear_results) begin
          result_next = `ARB_RES_RESET;
        end else if (chan_valid[ch]) begin
          result_next = chan_word[ch*`ARB_RES_W +: `ARB_RES_W] & chan_keep[ch*`ARB_RES_W +: `ARB_RES_W];
        end
      end

      always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          result_reg <= `ARB_RES_RESET;
        end else begin
          result_reg <= result_next;
        end
      end

      assign chan_result[ch*`ARB_RES_W +: `ARB_RES_W] = result_reg;
    end
  endgenerate

  // Per-channel views for the read mux
  assign bat_word = chan_result[`ARB_CH_BAT*`ARB_RES_W +: `ARB_RES_W];
  assign top_word = chan_result[`ARB_CH_TOP*`ARB_RES_W +: `ARB_RES_W];
  assign therm_word = chan_result[`ARB_CH_THERM*`ARB_RES_W +: `ARB_RES_W];

  // Defaults request: a held request re-arms only after the idle cycle
  always @* begin
    dflt_state_next = DFLT_IDLE;
    case (dflt_state_reg)
      DFLT_IDLE: begin
        if (reg_defaults_req_in)
          dflt_state_next = DFLT_PULSE;
      end
      DFLT_PULSE: begin
        dflt_state_next = DFLT_IDLE;
      end
      default: begin
        dflt_state_next = DFLT_IDLE;
      end
    endcase
    safety_timer_reset_next = (dflt_state_next == DFLT_PULSE);
    reg_defaults_busy_next = (dflt_state_next == DFLT_PULSE);
  end

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dflt_state_reg <= DFLT_IDLE;
    end else begin
      dflt_state_reg <= dflt_state_next;
    end
  end

  // Pulse outputs are registered copies of the next state
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      safety_timer_reset_out <= 1'b0;
    end else begin
      safety_timer_reset_out <= safety_timer_reset_next;
    end
  end

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_defaults_busy_out <= 1'b0;
    end else begin
      reg_defaults_busy_out <= reg_defaults_busy_next;
    end
  end

  // Writes have no path: every field here is read-only
  always @* begin
    rdata_next = rdata_out;
    rdata_valid_next = rd_strobe_in;
    if (rd_strobe_in) begin
      case (addr_in)
        `ARB_OFS_BAT_LOW: begin
          rdata_next = low_byte(bat_word);
        end
        `ARB_OFS_TOP_HIGH: begin
          rdata_next = high_byte(top_word);
        end
        `ARB_OFS_TOP_LOW: begin
          rdata_next = low_byte(top_word);
        end
        `ARB_OFS_THERM_HIGH: begin
          rdata_next = high_byte(therm_word);
        end
        default: begin
          rdata_next = `ARB_READ_UNMAPPED;
        end
      endcase
    end
  end

  // Read data holds until the next read
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= `ARB_RESET_VAL;
    end else begin
      rdata_out <= rdata_next;
    end
  end

  // One-cycle answer pulse per read strobe
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_valid_out <= 1'b0;
    end else begin
      rdata_valid_out <= rdata_valid_next;
    end
  end

endmodule // arb_result_bank

`default_nettype wire

// [src/arb_consts.vh]
// Constants for the converter result readback bank.
// Included by arb_result_bank.v; definitions only.
`ifndef ARB_CONSTS_VH
`define ARB_CONSTS_VH

`define ARB_ADDR_W 8
`define ARB_DATA_W 8
`define ARB_RES_W 16

`define ARB_OFS_BAT_LOW 8'h1E
`define ARB_OFS_TOP_HIGH 8'h1F
`define ARB_OFS_TOP_LOW 8'h20
`define ARB_OFS_THERM_HIGH 8'h21

`define ARB_RESET_VAL 8'h00
`define ARB_RES_RESET 16'h0000
`define ARB_READ_UNMAPPED 8'h00

`define ARB_SIGN_BIT 15
`define ARB_THERM_ZERO_HI 14
`define ARB_THERM_ZERO_LO 10
`define ARB_THERM_ZERO_MASK 16'h83FF
`define ARB_KEEP_ALL 16'hFFFF

`define ARB_N_CHAN 3
`define ARB_CH_BAT 0
`define ARB_CH_TOP 1
`define ARB_CH_THERM 2

`define ARB_LOW_HI 7
`define ARB_LOW_LO 0
`define ARB_HIGH_LO 8

`endif

// [test/arb_result_bank_assertions.sv]
// Checker on the result bank ports
// Bound to every arb_result_bank instance
`timescale 1ns/1ps
`default_nettype none
module arb_chk (input wire logic mclk_in, rstn_in, rd_strobe_in, rdata_valid_out, reg_defaults_req_in,
  input wire logic safety_timer_reset_out, reg_defaults_busy_out, input wire logic [7:0] addr_in, rdata_out);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  read_answer_a: assert property (rd_strobe_in |=> rdata_valid_out) else $error("no read answer");
  no_spur_a: assert property (!rd_strobe_in |=> !rdata_valid_out) else $error("spurious valid");
  unmapped_zero_a: assert property (rd_strobe_in && !(addr_in inside {[8'h1E:8'h21]}) |=> rdata_out == 8'h00)
    else $error("unmapped nonzero");
  therm_pad_a: assert property (rd_strobe_in && addr_in == 8'h21 |=> rdata_out[7] || rdata_out[6:2] == 5'h00)
    else $error("therm pad bits");
  data_hold_a: assert property (!rd_strobe_in |=> $stable(rdata_out)) else $error("rdata moved");
  dflt_once_a: assert property (safety_timer_reset_out |=> !safety_timer_reset_out) else $error("long pulse");
  dflt_pair_a: assert property (safety_timer_reset_out == reg_defaults_busy_out) else $error("busy split");
  dflt_answer_a: assert property (reg_defaults_req_in && !safety_timer_reset_out |=> safety_timer_reset_out)
    else $error("no defaults pulse");
  dflt_cause_a: assert property ($rose(safety_timer_reset_out) |-> $past(reg_defaults_req_in))
    else $error("pulse no cause");
  cover property (rd_strobe_in && addr_in == 8'h21);
  cover property (rd_strobe_in ##1 rd_strobe_in);
  cover property (reg_defaults_busy_out);
endmodule // arb_chk
bind arb_result_bank arb_chk chk_u (.mclk_in, .rstn_in, .rd_strobe_in, .rdata_valid_out, .reg_defaults_req_in,
  .safety_timer_reset_out, .reg_defaults_busy_out, .addr_in, .rdata_out);
`default_nettype wire

// [test/arb_host.sv]
// Host model issuing one-cycle register reads
// Assumes reads are answered by the bank itself
`timescale 1ns/1ps
`default_nettype none
module arb_host (input wire logic clk, output logic rd, output logic [7:0] addr);
  initial begin
    rd = 1'b0;
    addr = 8'h00;
  end
  task automatic rd_req(input logic [7:0] a);
    @(posedge clk);
    #2 rd = 1'b1;
    addr = a;
    @(posedge clk);
    // Released bus shows inverse, not the stale offset
    #2 rd = 1'b0;
    addr = ~a;
  endtask
  // Points the offset at a register without a read, for ignored writes
  task automatic aim(input logic [7:0] a);
    addr = a;
  endtask
endmodule // arb_host
`default_nettype wire

// [test/tb_top.sv]
// Bench: loads random results, reads them back, checks clears
// Uses arb_host and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk_in = 0, rstn_in = 0, rd, bv = 0, wr = 0, dreq = 0, wd = 0, vld, str, bsy;
  logic [7:0] addr, rdata, wdat = 8'h00, exp_q[$];
  logic [15:0] b = 16'h0000, t = 16'h0000, h = 16'h0000, s = 16'h321E;
  int bad_count = 0, n_compared = 0;
  always #25 mclk_in = ~mclk_in;
  arb_host host_u (.clk(mclk_in), .rd(rd), .addr(addr));
  arb_result_bank dut_u (.mclk_in(mclk_in), .rstn_in(rstn_in), .bat_result_valid_in(bv), .bat_result_in(b),
    .top_result_valid_in(bv), .top_result_in(t), .therm_result_valid_in(bv), .therm_result_in(h),
    .rd_strobe_in(rd), .wr_strobe_in(wr), .addr_in(addr), .wdata_in(wdat), .rdata_out(rdata),
    .rdata_valid_out(vld), .reg_defaults_req_in(dreq), .watchdog_expired_in(wd),
    .safety_timer_reset_out(str), .reg_defaults_busy_out(bsy));
  function automatic logic [15:0] nx(input logic [15:0] v);
    v ^= v << 7;
    v ^= v >> 9;
    v ^= v << 8;
    return v;
  endfunction
  task automatic check(input logic [7:0] seen, e);
    n_compared++;
    if (seen !== e) begin
      bad_count++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, e);
    end
  endtask
  task automatic rdall(input logic [15:0] bb, tt, hh);
    exp_q = {exp_q, bb[7:0], tt[15:8], tt[7:0], (hh[15] ? hh[15:8] : hh[15:8] & 8'h83), 8'h00};
    for (int k = 0; k < 5; k++) host_u.rd_req(8'h1E + k[7:0]);
  endtask
  task automatic summarize();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge mclk_in) if (vld === 1'b1) check(rdata, exp_q.pop_front());
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge mclk_in);
    #2 rstn_in = 1;
    rdall(0, 0, 0);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      s = nx(s); b = s; s = nx(s); t = s; s = nx(s); h = s; bv = 1;
      @(posedge mclk_in);
      // Ignored write and watchdog must not disturb results
      #2 bv = 0; wr = 1; wd = 1; wdat = s[7:0];
      host_u.aim(8'h1E + {6'h00, s[9:8]});
      @(posedge mclk_in);
      #2 wr = 0; wd = 0;
      rdall(b, t, h);
      @(posedge mclk_in);
      #2 dreq = 1;
      @(posedge mclk_in);
      #2 dreq = 0;
      check({str, bsy, 6'h00}, 8'hC0);
      @(posedge mclk_in);
      #2 check({str, bsy, 6'h00}, 8'h00);
      repeat (2) @(posedge mclk_in);
      rdall(0, 0, 0);
      $display("round %0d done", i);
    end
    s = nx(s); b = s; bv = 1;
    @(posedge mclk_in);
    #2 bv = 0; rstn_in = 0;
    @(posedge mclk_in);
    #2 rstn_in = 1;
    rdall(0, 0, 0);
    $display("mid-run reset done");
    repeat (4) @(posedge mclk_in);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
